//--- lcss_consts.svh
// Purpose: named constants of the common scan shifter
// Assumes: included by bare name
// Notes: level codes are the values on the per-row select outputs
`ifndef LCSS_CONSTS_SVH
`define LCSS_CONSTS_SVH
`define LCSS_STAGES 32
`define LCSS_FIFO_DEPTH 8
`define LCSS_FIFO_WIDTH 1
`define LCSS_LVL_FIRST 2'h0
`define LCSS_LVL_SECOND 2'h1
`define LCSS_LVL_THIRD 2'h2
`define LCSS_LVL_FOURTH 2'h3
`define LCSS_LVL_W 2
`define LCSS_PAIR_LOW_LOW 2'h0
`define LCSS_PAIR_LOW_HIGH 2'h1
`define LCSS_PAIR_HIGH_LOW 2'h2
`define LCSS_PAIR_HIGH_HIGH 2'h3
`define LCSS_BIT_RESET 1'h0
`endif

//--- lcss_pkg.sv
// Purpose: types of the common scan shifter
// Assumes: nothing
// Notes: level code values live in lcss_consts.svh
package lcss_pkg;
	typedef logic [1:0] lcss_level_t;
	typedef logic [31:0] lcss_stages_t;
endpackage

//--- lcss_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
module lcss_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage needs no reset: a word is only read after it was written
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule // lcss_fifo

//--- lcss_top.sv
// Purpose: 32-stage common row scan shifter with four-level row select
// Assumes: all inputs synchronous to clk_sys; shift_clock slower than clk_sys/2
// Notes: the shift clock is sampled, not used as a clock
`timescale 1ns/1ps
`include "lcss_consts.svh"

module lcss_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link from the timing controller
	input wire logic shift_clock,
	input wire logic scan_serial_in,
	input wire logic frame_alternation,
	// drain stall, e.g. freezing the rows while the panel is blanked
	input wire logic scan_hold,
	// cascade and status
	output logic scan_serial_out,
	output logic scan_ready,
	// per-row level select, row n at bits [2n+1:2n]
	output logic [2*`LCSS_STAGES-1:0] common_row_outputs
);
	// edge detector on the sampled shift clock
	logic clk_prev_q, clk_prev_d;
	logic edge_fall;
	// fifo between capture and shift
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_pop;
	logic [`LCSS_FIFO_WIDTH-1:0] fifo_out_data;
	// stage bits gathered from the per-stage flops
	wire lcss_pkg::lcss_stages_t stage_bits;
	wire lcss_pkg::lcss_stages_t stage_feed;
	// fifo space status
	logic ready_q, ready_d;

	// edge group: the sample resets low so an idle-low clock right
	// after reset is not taken for a falling edge
	always_comb begin
		clk_prev_d = shift_clock;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clk_prev_q <= `LCSS_BIT_RESET;
		end else begin
			clk_prev_q <= clk_prev_d;
		end
	end

	assign edge_fall = clk_prev_q && !shift_clock;

	// the fifo decouples capture from the shift; if scan_hold stays high
	// for more than eight edges, later bits are dropped and scan_ready shows it
	lcss_fifo #(
		.WIDTH(`LCSS_FIFO_WIDTH),
		.DEPTH(`LCSS_FIFO_DEPTH)
	) i_lcss_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(edge_fall),
		.in_data(scan_serial_in),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_out_ready)
	);

	assign fifo_out_ready = !scan_hold;
	assign fifo_pop = fifo_out_valid && fifo_out_ready;

	// stage one takes the fifo head, every other stage its lower neighbour
	assign stage_feed = {stage_bits[`LCSS_STAGES-2:0], fifo_out_data[0]};

	// one flop and one level select per stage; the select is taken from the
	// next stage value so a row lands together with the stage it follows
	genvar gi;
	generate
		for (gi = 0; gi < `LCSS_STAGES; gi++) begin : g_stage
			logic bit_q, bit_d;
			lcss_pkg::lcss_level_t code_q, code_d;

			always_comb begin
				bit_d = bit_q;
				if (fifo_pop) begin
					bit_d = stage_feed[gi];
				end
				case ({bit_d, frame_alternation})
					`LCSS_PAIR_LOW_LOW: begin
						code_d = `LCSS_LVL_SECOND;
					end
					`LCSS_PAIR_LOW_HIGH: begin
						code_d = `LCSS_LVL_FOURTH;
					end
					`LCSS_PAIR_HIGH_LOW: begin
						code_d = `LCSS_LVL_THIRD;
					end
					`LCSS_PAIR_HIGH_HIGH: begin
						code_d = `LCSS_LVL_FIRST;
					end
					default: begin
						code_d = `LCSS_LVL_SECOND;
					end
				endcase
			end

			// stages are cleared although only 32 shifts make them meaningful;
			// a known start is cheaper to check than an undefined one
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					bit_q <= `LCSS_BIT_RESET;
					code_q <= `LCSS_LVL_SECOND;
				end else begin
					bit_q <= bit_d;
					code_q <= code_d;
				end
			end

			assign stage_bits[gi] = bit_q;
			assign common_row_outputs[`LCSS_LVL_W*gi +: `LCSS_LVL_W] = code_q;
		end
	endgenerate

	// status group: a registered copy of fifo space, one cycle late
	always_comb begin
		ready_d = fifo_in_ready;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ready_q <= `LCSS_BIT_RESET;
		end else begin
			ready_q <= ready_d;
		end
	end

	assign scan_serial_out = stage_bits[`LCSS_STAGES-1];
	assign scan_ready = ready_q;
endmodule // lcss_top

//--- lcss_properties.sv
// Purpose: port checks of the scan shifter
// Assumes: bound to lcss_top
// Notes: stage bits are read back from the row codes
`timescale 1ns/1ps
`include "lcss_consts.svh"
module lcss_properties (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// watched ports
	input wire logic frame_alternation,
	input wire logic scan_hold,
	input wire logic scan_serial_out,
	input wire logic scan_ready,
	input wire logic [2*`LCSS_STAGES-1:0] common_row_outputs
);
	logic [`LCSS_STAGES-1:0] st;
	logic [`LCSS_STAGES-1:0] hi;
	always_comb begin
		for (int i = 0; i < `LCSS_STAGES; i++) begin
			st[i] = ~common_row_outputs[2*i];
			hi[i] = common_row_outputs[2*i+1];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_tail_match: assert property (scan_serial_out == st[31])
		else $error("cascade bit differs from last row");
	a_row_shift: assert property (st != $past(st) && !$past(reset) |->
		st[31:1] == $past(st[30:0])) else $error("rows did not move by one");
	a_level_map: assert property (!$past(reset) |->
		hi == (st ^ {32{$past(frame_alternation)}})) else $error("level code wrong");
	a_hold_freeze: assert property (scan_hold |=> st == $past(st))
		else $error("rows moved while held");
	a_reset_clear: assert property ($past(reset) |->
		common_row_outputs == {32{`LCSS_LVL_SECOND}}) else $error("reset rows wrong");
	a_ready_release: assert property ($past(reset) |->
		!scan_ready ##1 scan_ready) else $error("ready wrong after reset");
endmodule // lcss_properties

//--- lcss_ctrl_model.sv
// Purpose: timing controller and cascaded second device, one shift per go pulse
// Assumes: go pulses at least two cycles apart
// Notes: data line toggles outside a shift, so stale bits never look held
`timescale 1ns/1ps
module lcss_ctrl_model (
	// control
	input wire logic clk_sys,
	input wire logic go,
	input wire logic din,
	// link
	output logic shift_clock,
	output logic scan_serial_in,
	// second device of the chain
	input wire logic cascade_in,
	output logic cascade_out
);
	logic [31:0] chain_q;
	initial shift_clock = 1'h1;
	initial scan_serial_in = 1'h0;
	initial chain_q = '0;
	// the chained device takes the cascade bit on the same falling edge
	always @(posedge clk_sys) begin
		if (go) chain_q <= {chain_q[30:0], cascade_in};
	end
	assign cascade_out = chain_q[31];
	always @(posedge clk_sys) begin
		shift_clock <= #1 !go;
		scan_serial_in <= #1 go ? din : !scan_serial_in;
	end
endmodule // lcss_ctrl_model

//--- tb_top.sv
// Purpose: self-checking bench of the scan shifter
// Assumes: 40 MHz clk_sys
// Notes: the drain is stalled to fill the fifo
`timescale 1ns/1ps
`include "lcss_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
	$display("mismatch %0t value differs", $time); end end
module tb_top;
	logic clk_sys = 0;
	logic reset = 1;
	logic go = 0;
	logic din = 0;
	logic alt = 0;
	logic hold = 0;
	logic sck, sin, sout, rdy, tail;
	logic [63:0] rows;
	int n_mismatch = 0;
	int check_count = 0;
	lcss_ctrl_model i_lcss_ctrl_model (.clk_sys(clk_sys), .go(go), .din(din),
		.shift_clock(sck), .scan_serial_in(sin), .cascade_in(sout), .cascade_out(tail));
	lcss_top i_lcss_top (.clk_sys(clk_sys), .reset(reset), .shift_clock(sck),
		.scan_serial_in(sin), .frame_alternation(alt), .scan_hold(hold),
		.scan_serial_out(sout), .scan_ready(rdy), .common_row_outputs(rows));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic send(logic b);
		tick(1);
		go = 1;
		din = b;
		tick(1);
		go = 0;
		tick(2);
	endtask
	task automatic fill_drop;
		hold = 1;
		repeat (9) send(1);
		`CHK(rdy, 1'h0)
		`CHK(rows, {32{`LCSS_LVL_SECOND}})
		hold = 0;
		tick(9);
		`CHK(rows[17:0], {`LCSS_LVL_SECOND, {8{`LCSS_LVL_THIRD}}})
	endtask
	task automatic levels(logic b, logic [1:0] lo, logic [1:0] up);
		send(b);
		`CHK(rows[1:0], lo)
		alt = 1;
		tick(2);
		`CHK(rows[1:0], up)
		alt = 0;
	endtask
	task automatic cascade;
		send(1);
		repeat (31) send(0);
		`CHK(sout, 1'h1)
		`CHK(rows[63:62], `LCSS_LVL_THIRD)
		send(0);
		`CHK(sout, 1'h0)
		repeat (30) send(0);
		`CHK(tail, 1'h0)
		send(0);
		`CHK(tail, 1'h1)
		send(0);
		`CHK(tail, 1'h0)
	endtask
	task automatic end_of_test;
		if (n_mismatch == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		tick(12);
		reset = 0;
		fill_drop();
		levels(1, `LCSS_LVL_THIRD, `LCSS_LVL_FIRST);
		levels(0, `LCSS_LVL_SECOND, `LCSS_LVL_FOURTH);
		cascade();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		end_of_test();
	end
endmodule // tb_top
bind lcss_top lcss_properties i_lcss_properties (.clk_sys(clk_sys), .reset(reset),
	.frame_alternation(frame_alternation), .scan_hold(scan_hold),
	.scan_serial_out(scan_serial_out), .scan_ready(scan_ready),
	.common_row_outputs(common_row_outputs));
